// File: src/tap_params.svh
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH

// ************************************************************
// scan path lengths and cell positions
// ************************************************************
`define IR_LEN          3
`define ID_LEN          32
`define BS_LEN          109
`define BS_OE_CELL      108
`define BS_OE_RESET     1'b1
`define IR_CAPTURE_VAL  3'h1

// ************************************************************
// identification word field positions
// ************************************************************
`define ID_REV_LSB      29
`define ID_DEV_LSB      12
`define ID_VEN_LSB      1
`define ID_PRESENT_BIT  0

// ************************************************************
// timing
// ************************************************************
`define SYS_CLK_NS      100
`define TCK_MIN_HIGH_NS 20
`define TCK_MIN_HIGH_CYC \
  (((`TCK_MIN_HIGH_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS) < 1 ? 1 : \
   ((`TCK_MIN_HIGH_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS))
`define TCK_HALF_CYC    8
`define DLL_LOCK_CYCLES 1024

// ************************************************************
// controller register map (byte offsets) and fields
// ************************************************************
`define REG_CTRL        5'h00
`define REG_TMS         5'h04
`define REG_TDI         5'h08
`define REG_TDO         5'h0C
`define REG_DLL         5'h10
`define CTRL_START_BIT  8
`define CTRL_BUSY_BIT   0
`define DLL_EN_BIT      0
`define DLL_RELOCK_BIT  1
`define DLL_READY_BIT   2
`define DLL_EN_RESET    1'b1

`endif

// File: src/tap_pkg.sv
`default_nettype none
package tap_pkg;
  `include "tap_params.svh"

  typedef enum logic [3:0] {
    ST_TLR    = 4'b0000, ST_IDLE   = 4'b0001, ST_SEL_DR = 4'b0010, ST_CAP_DR = 4'b0011,
    ST_SH_DR  = 4'b0100, ST_EX1_DR = 4'b0101, ST_PAU_DR = 4'b0110, ST_EX2_DR = 4'b0111,
    ST_UPD_DR = 4'b1000, ST_SEL_IR = 4'b1001, ST_CAP_IR = 4'b1010, ST_SH_IR  = 4'b1011,
    ST_EX1_IR = 4'b1100, ST_PAU_IR = 4'b1101, ST_EX2_IR = 4'b1110, ST_UPD_IR = 4'b1111
  } tap_state_type;

  typedef enum logic [2:0] {
    INS_PIN_DRIVE     = 3'b000,
    INS_ID_READ       = 3'b001,
    INS_FLOAT_CAPTURE = 3'b010,
    INS_SPARE_3       = 3'b011,
    INS_CAPTURE       = 3'b100,
    INS_SPARE_5       = 3'b101,
    INS_SPARE_6       = 3'b110,
    INS_PASS          = 3'b111
  } instr_type;

  typedef enum logic [1:0] {
    PATH_PASS  = 2'b00,
    PATH_ID    = 2'b01,
    PATH_CHAIN = 2'b10
  } path_type;

  typedef struct packed {
    tap_state_type st;
  } fsm_reg_type;

  typedef struct packed {
    logic                tck_s1, tck_s2, tck_p;
    logic                tms_s1, tms_s2;
    logic                tdi_s1, tdi_s2;
    logic                dll_s1, dll_s2;
    logic [`IR_LEN-1:0]  ir_sr;
    instr_type           ir_q;
    logic                byp;
    logic [`ID_LEN-1:0]  id_sr;
    logic [`BS_LEN-1:0]  bs_sr;
    logic [`BS_LEN-1:0]  bs_upd;
    logic                tdo;
    logic                tdo_oe;
    logic [10:0]         dll_cnt;
    logic                dll_locked;
  } dev_reg_type;

  typedef struct packed {
    logic        tck, tms, tdi;
    logic        tdo_s1, tdo_s2;
    logic [7:0]  div;
    logic [4:0]  idx;
    logic [4:0]  len;
    logic        busy;
    logic [31:0] tms_vec, tdi_vec, tdo_vec;
    logic        ack;
    logic [31:0] rdata;
    logic        dll_en;
    logic [10:0] lock_cnt;
  } host_reg_type;
endpackage
`default_nettype wire

// File: src/tap_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tap_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo_drv;
  logic tdo_oe;
  logic tdo;
  logic dll_enable_pin;

  // board pull-up holds the line high while the port floats it
  assign tdo = tdo_oe ? tdo_drv : 1'b1;

  modport device (input tck, input tms, input tdi, input dll_enable_pin,
                  output tdo_drv, output tdo_oe);
  modport controller (output tck, output tms, output tdi, output dll_enable_pin,
                      input tdo);
endinterface
`default_nettype wire

// File: src/tap_fsm.sv
`timescale 1ns/10ps
`default_nettype none
module tap_fsm (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // link step, one pulse per test clock rise
  input  wire logic                   step,
  input  wire logic                   tms,
  // port controller state
  output var  tap_pkg::tap_state_type state
);
  import tap_pkg::*;

  fsm_reg_type q;
  fsm_reg_type d;

  // ************************************************************
  // sixteen-state walk steered by tms at each rise
  // ************************************************************
  function automatic tap_state_type next_state(input tap_state_type s, input logic m);
    tap_state_type n;
    n = s;
    case (s)
      ST_TLR:    n = m ? ST_TLR    : ST_IDLE;
      ST_IDLE:   n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: n = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: n = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  n = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: n = m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: n = m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: n = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: n = m ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: n = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  n = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: n = m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: n = m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: n = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: n = m ? ST_SEL_DR : ST_IDLE;
      default:   n = ST_TLR;
    endcase
    return n;
  endfunction

  // advance only on a detected test clock rise
  always_comb begin
    d = q;
    if (step) begin
      d.st = next_state(q.st, tms);
    end
  end

  // power-up lands in logic reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: ST_TLR};
    end else begin
      q <= d;
    end
  end

  assign state = q.st;
endmodule
`default_nettype wire

// File: src/sram_boundary_scan_tap.sv
`timescale 1ns/10ps
`default_nettype none
`include "tap_params.svh"
module sram_boundary_scan_tap #(
  parameter int             LOCK_CYCLES = `DLL_LOCK_CYCLES,
  parameter logic [2:0]     ID_REV      = 3'h1,     // arbitrary value
  parameter logic [16:0]    ID_DEVICE   = 17'h0ABCD, // arbitrary value
  parameter logic [10:0]    ID_VENDOR   = 11'h2A5   // arbitrary value
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // scan link
  tap_link_if.device                link,
  // memory pin ring
  input  wire logic [`BS_LEN-2:0]   pin_sample,
  output logic      [`BS_LEN-2:0]   pin_drive_val,
  output logic                      pin_drive_en,
  output logic                      read_bus_oe,
  // data-path delay loop
  output logic                      dll_locked
);
  import tap_pkg::*;

  // registered state, its next value and the decoded test clock edges
  dev_reg_type   q;
  dev_reg_type   d;
  tap_state_type tap_st;
  logic          rise;
  logic          fall;

  // ************************************************************
  // fixed values
  // ************************************************************
  // identification word: every field fixed, presence bit forced high
  localparam logic [`ID_LEN-1:0] ID_WORD =
      (`ID_LEN'(ID_REV) << `ID_REV_LSB) |
      (`ID_LEN'(ID_DEVICE) << `ID_DEV_LSB) |
      (`ID_LEN'(ID_VENDOR) << `ID_VEN_LSB) |
      (`ID_LEN'(1) << `ID_PRESENT_BIT);

  // power-up image: identification instruction, output-enable cell high
  localparam dev_reg_type DEV_RST = '{
      ir_q:   INS_ID_READ,
      bs_upd: {`BS_OE_RESET, {(`BS_LEN-1){1'b0}}},
      default: '0};

  // ************************************************************
  // instruction decode
  // ************************************************************
  // spare codes fall to the pass register so a stray load stays harmless
  // every instruction maps to exactly one data path
  function automatic path_type path_of(input instr_type i);
    path_type p;
    case (i)
      INS_ID_READ:       p = PATH_ID;
      INS_PIN_DRIVE,
      INS_FLOAT_CAPTURE,
      INS_CAPTURE:       p = PATH_CHAIN;
      default:           p = PATH_PASS;
    endcase
    return p;
  endfunction

  // ************************************************************
  // edge detection on the synchronised test clock
  // ************************************************************
  // tms and tdi pass the same two stages, so they stay aligned to the edge
  assign rise = q.tck_s2 & ~q.tck_p;
  assign fall = ~q.tck_s2 & q.tck_p;

  // the port controller walk lives in its own module, stepped by each rise
  tap_fsm u_fsm (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .step    (rise),
    .tms     (q.tms_s2),
    .state   (tap_st)
  );

  // ************************************************************
  // scan registers, output stage, lock counter
  // ************************************************************
  always_comb begin
    d        = q;
    // every link pin passes two flip-flops before any logic reads it
    d.tck_s1 = link.tck;
    d.tck_s2 = q.tck_s1;
    d.tck_p  = q.tck_s2;
    d.tms_s1 = link.tms;
    d.tms_s2 = q.tms_s1;
    d.tdi_s1 = link.tdi;
    d.tdi_s2 = q.tdi_s1;
    d.dll_s1 = link.dll_enable_pin;
    d.dll_s2 = q.dll_s1;
    // actions belong to the state being left at this rise
    if (rise) begin
      case (tap_st)
        // capture: parallel load of the selected data path
        ST_CAP_DR: begin
          case (path_of(q.ir_q))
            PATH_ID:    d.id_sr = ID_WORD;
            PATH_CHAIN: d.bs_sr = {q.bs_upd[`BS_OE_CELL], pin_sample};
            default:    d.byp   = 1'b0;
          endcase
        end
        // shift: one step toward the serial output, lsb first
        ST_SH_DR: begin
          case (path_of(q.ir_q))
            PATH_ID:    d.id_sr = {q.tdi_s2, q.id_sr[`ID_LEN-1:1]};
            PATH_CHAIN: d.bs_sr = {q.tdi_s2, q.bs_sr[`BS_LEN-1:1]};
            default:    d.byp   = q.tdi_s2;
          endcase
        end
        // update: only the chain has a pin-side latch
        ST_UPD_DR: begin
          if (path_of(q.ir_q) == PATH_CHAIN) begin
            d.bs_upd = q.bs_sr;
          end
        end
        // instruction path: fixed capture pattern, shift, then load
        ST_CAP_IR: d.ir_sr = `IR_CAPTURE_VAL;
        ST_SH_IR:  d.ir_sr = {q.tdi_s2, q.ir_sr[`IR_LEN-1:1]};
        // the new instruction takes effect as the walk leaves update
        ST_UPD_IR: d.ir_q  = instr_type'(q.ir_sr);
        default: begin
          // other states keep every register
        end
      endcase
    end
    // logic reset holds the default instruction and the driver-enable preset
    if (tap_st == ST_TLR) begin
      d.ir_q               = INS_ID_READ;
      d.bs_upd[`BS_OE_CELL] = `BS_OE_RESET;
    end
    // output changes only after a fall, giving the far end a full half period
    if (fall) begin
      // the line is driven only in the two shift states
      d.tdo_oe = (tap_st == ST_SH_DR) || (tap_st == ST_SH_IR);
      if (tap_st == ST_SH_IR) begin
        d.tdo = q.ir_sr[0];
      end else begin
        // pass is the fallback, so a spare code still gives a defined bit
        case (path_of(q.ir_q))
          PATH_ID:    d.tdo = q.id_sr[0];
          PATH_CHAIN: d.tdo = q.bs_sr[0];
          default:    d.tdo = q.byp;
        endcase
      end
    end
    // lock counts rising clock edges while the enable pin stays high
    // the count saturates, so the flag holds until the pin drops
    if (!q.dll_s2) begin
      d.dll_cnt    = '0;
      d.dll_locked = 1'b0;
    end else if (q.dll_cnt != 11'(LOCK_CYCLES)) begin
      d.dll_cnt    = q.dll_cnt + 11'h001;
    end else begin
      d.dll_locked = 1'b1;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  // asynchronous reset loads the power-up image
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // pin-side outputs, all decoded from registered state
  // ************************************************************
  // serial driver straight from flip-flops
  assign link.tdo_drv  = q.tdo;
  assign link.tdo_oe   = q.tdo_oe;
  // pin ring: latched values, enabled only by the drive instruction
  assign pin_drive_val = q.bs_upd[`BS_LEN-2:0];
  assign pin_drive_en  = (q.ir_q == INS_PIN_DRIVE);
  // identification, capture and pass leave the read bus enabled
  assign read_bus_oe   = (q.ir_q == INS_PIN_DRIVE) ? q.bs_upd[`BS_OE_CELL] :
                         (q.ir_q == INS_FLOAT_CAPTURE) ? 1'b0 : 1'b1;
  // lock flag is registered, never decoded
  assign dll_locked    = q.dll_locked;
endmodule
`default_nettype wire

// File: src/scan_test_controller.sv
`timescale 1ns/10ps
`default_nettype none
`include "tap_params.svh"
module scan_test_controller #(
  parameter int HALF_CYC    = `TCK_HALF_CYC,
  parameter int LOCK_CYCLES = `DLL_LOCK_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // memory clock health
  input  wire logic        mem_clk_unstable,
  output logic             mem_ready,
  // scan link
  tap_link_if.controller   link
);
  import tap_pkg::*;

  host_reg_type q;
  host_reg_type d;
  logic         req_new;
  logic         wr_take;

  localparam host_reg_type HOST_RST = '{dll_en: `DLL_EN_RESET, default: '0};

  // half period is raised to no less than the minimum high time in clock cycles
  localparam int HALF = (HALF_CYC < `TCK_MIN_HIGH_CYC) ? `TCK_MIN_HIGH_CYC : HALF_CYC;

  // one wait cycle, then the answer; write lands on the edge waitrequest is low
  assign req_new = (avs_read | avs_write) & ~q.ack;
  assign wr_take = avs_write & q.ack;

  // ************************************************************
  // register access, scan sequencer, lock timer
  // ************************************************************
  always_comb begin
    d        = q;
    d.tdo_s1 = link.tdo;
    d.tdo_s2 = q.tdo_s1;
    d.ack    = req_new;
    if (req_new && avs_read) begin
      d.rdata = '0;
      if (avs_address == `REG_CTRL) begin
        d.rdata[`CTRL_BUSY_BIT] = q.busy;
      end else if (avs_address == `REG_TMS) begin
        d.rdata = q.tms_vec;
      end else if (avs_address == `REG_TDI) begin
        d.rdata = q.tdi_vec;
      end else if (avs_address == `REG_TDO) begin
        d.rdata = q.tdo_vec;
      end else if (avs_address == `REG_DLL) begin
        d.rdata[`DLL_EN_BIT]    = q.dll_en;
        d.rdata[`DLL_READY_BIT] = q.dll_en && (q.lock_cnt == 11'(LOCK_CYCLES));
      end
    end
    // tms drives the walk at the device's rise, so it moves only at our fall
    if (q.busy) begin
      if (q.div == 8'(HALF - 1)) begin
        d.tck            = 1'b1;
        d.tdo_vec[q.idx] = q.tdo_s2;
        d.div            = q.div + 8'h01;
      end else if (q.div == 8'(2 * HALF - 1)) begin
        d.tck = 1'b0;
        d.div = '0;
        if (q.idx == q.len) begin
          d.busy = 1'b0;
        end else begin
          d.idx = q.idx + 5'h01;
          d.tms = q.tms_vec[q.idx + 5'h01];
          d.tdi = q.tdi_vec[q.idx + 5'h01];
        end
      end else begin
        d.div = q.div + 8'h01;
      end
    end
    // the tms and tdi vectors are frozen while a sequence runs
    if (wr_take && !q.busy) begin
      if (avs_address == `REG_CTRL) begin
        if (avs_writedata[`CTRL_START_BIT]) begin
          d.busy = 1'b1;
          d.len  = avs_writedata[4:0];
          d.idx  = '0;
          d.div  = '0;
          d.tck  = 1'b0;
          d.tms  = q.tms_vec[0];
          d.tdi  = q.tdi_vec[0];
        end
      end else if (avs_address == `REG_TMS) begin
        d.tms_vec = avs_writedata;
      end else if (avs_address == `REG_TDI) begin
        d.tdi_vec = avs_writedata;
      end
    end
    // the enable pin register works even during a sequence
    if (wr_take && (avs_address == `REG_DLL)) begin
      d.dll_en = avs_writedata[`DLL_EN_BIT];
    end
    // any doubt about the clock restarts the full lock wait
    if (!q.dll_en || mem_clk_unstable ||
        (wr_take && (avs_address == `REG_DLL) && avs_writedata[`DLL_RELOCK_BIT])) begin
      d.lock_cnt = '0;
    end else if (q.lock_cnt != 11'(LOCK_CYCLES)) begin
      d.lock_cnt = q.lock_cnt + 11'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= HOST_RST;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign avs_waitrequest     = req_new;
  assign avs_readdata        = q.rdata;
  assign link.tck            = q.tck;
  assign link.tms            = q.tms;
  assign link.tdi            = q.tdi;
  assign link.dll_enable_pin = q.dll_en;
  assign mem_ready           = q.dll_en && (q.lock_cnt == 11'(LOCK_CYCLES));
endmodule
`default_nettype wire

// File: verif/sram_boundary_scan_tap_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module tap_link_assertions (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // scan link
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo_drv,
  input wire logic tdo_oe,
  input wire logic dll_enable_pin
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ************************************************************
  // link timing
  // ************************************************************
  // both halves must outlast the port's two-stage synchronizer
  tck_high_a: assert property ($rose(tck) |-> tck [*8] ##1 !tck)
    else $error("test clock high half wrong");
  tck_low_a: assert property ($fell(tck) |-> (!tck) [*8])
    else $error("test clock low half too short");
  data_hold_a: assert property (tck |-> $stable(tms) && $stable(tdi))
    else $error("mode or data moved while test clock high");
  tdo_fall_a: assert property ($changed(tdo_drv) |-> !tck && !$past(tck))
    else $error("serial out moved outside the low half");
  // the port only reacts to a fall after its synchronizer delay
  tdo_delay_a: assert property ($fell(tck) |-> $stable(tdo_drv) ##1 $stable(tdo_drv))
    else $error("serial out moved too soon after fall");
  oe_rise_a: assert property ($rose(tdo_oe) |-> !tck && !$past(tck))
    else $error("serial out enable rose outside low half");
  oe_fall_a: assert property ($fell(tdo_oe) |-> !tck ##1 !tck)
    else $error("serial out enable fell outside low half");
  reset_idle_a: assert property ($rose(rst_n) |-> dll_enable_pin && !tck && !tdo_oe)
    else $error("link not idle after reset");
endmodule
`default_nettype wire

// File: verif/test_sram_boundary_scan_tap.sv
`timescale 1ns/10ps
`default_nettype none
`include "tap_params.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module test_sram_boundary_scan_tap;
  localparam int           LOCK   = 16;
  localparam logic [31:0]  ID_EXP = {3'h1, 17'h0ABCD, 11'h2A5, 1'b1};
  localparam logic [107:0] PINS   = {27{4'hB}};
  localparam logic [127:0] S1     = 128'h0000_1234_5678_9ABC_DEF0_1357_9BDF_0246;
  localparam logic [127:0] S2     = 128'h0000_3FED_CBA9_8765_4321_0ECA_8642_F00F;
  logic         sys_clk, rst_n, rd, wr, unstable, locked, ready, drive_en, bus_oe, waitreq;
  logic [4:0]   addr;
  logic [31:0]  wdata, rdata;
  logic [107:0] drive_val;
  int           fails, checked;
  tap_link_if link ();
  sram_boundary_scan_tap #(.LOCK_CYCLES(LOCK), .ID_REV(3'h1), .ID_DEVICE(17'h0ABCD),
    .ID_VENDOR(11'h2A5)) sram_boundary_scan_tap_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .link(link), .pin_sample(PINS), .pin_drive_val(drive_val), .pin_drive_en(drive_en),
    .read_bus_oe(bus_oe), .dll_locked(locked));
  scan_test_controller #(.LOCK_CYCLES(LOCK)) scan_test_controller_inst (.sys_clk(sys_clk),
    .rst_n(rst_n), .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_readdata(rdata), .avs_waitrequest(waitreq), .mem_clk_unstable(unstable),
    .mem_ready(ready), .link(link));
  tap_link_assertions tap_link_assertions_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo_drv(link.tdo_drv),
    .tdo_oe(link.tdo_oe), .dll_enable_pin(link.dll_enable_pin));
  // ************************************************************
  // bus and scan helpers
  // ************************************************************
  // request stands until waitrequest is seen low at a rising edge; data taken there
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    if (n == 50) fails++;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic scan(input int n, input logic [31:0] m, input logic [31:0] d,
                      output logic [31:0] q);
    logic [31:0] r;
    int k;
    av(1'b1, `REG_TMS, m, r);
    av(1'b1, `REG_TDI, d, r);
    av(1'b1, `REG_CTRL, (32'h1 << `CTRL_START_BIT) | 32'(n - 1), r);
    k = 0;
    do begin
      av(1'b0, `REG_CTRL, 32'h0, r);
      k++;
    end while (r[`CTRL_BUSY_BIT] !== 1'b0 && k < 300);
    if (k == 300) fails++;
    av(1'b0, `REG_TDO, 32'h0, q);
  endtask
  // idle to shift, chunks of at most 32 bits, then update and back to idle
  task automatic dr(input int n, input logic [127:0] s, output logic [127:0] o);
    logic [31:0] q;
    int p, l;
    o = '0;
    scan(3, 32'h1, 32'h0, q);
    for (p = 0; p < n; p += 32) begin
      l = (n - p < 32) ? n - p : 32;
      scan(l, (p + l == n) ? 32'h1 << (l - 1) : 32'h0, s[p +: 32], q);
      o[p +: 32] = q;
    end
    scan(2, 32'h1, 32'h0, q);
  endtask
  task automatic ir(input logic [2:0] c);
    logic [31:0] q;
    scan(9, 32'hC3, {25'h0, c, 4'h0}, q);
    `CHK("ir capture", `IR_CAPTURE_VAL, q[6:4])
  endtask
  task automatic wait_on(input bit sel, input logic v, output int n);
    n = 0;
    while ((sel ? ready : locked) !== v && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic regs();
    logic [31:0] r;
    `CHK("tdo pull", 1'b1, link.tdo)
    `CHK("reset bus oe", 1'b1, bus_oe)
    `CHK("reset drive en", 1'b0, drive_en)
    av(1'b1, 5'h14, 32'hFFFF_FFFF, r);
    av(1'b0, 5'h14, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
    av(1'b0, `REG_DLL, 32'h0, r);
    `CHK("dll enable", 1'b1, r[`DLL_EN_BIT])
  endtask
  task automatic ident();
    logic [127:0] o;
    scan(1, 32'h0, 32'h0, o[31:0]);
    dr(32, '0, o);
    `CHK("id word", ID_EXP, o[31:0])
    `CHK("id present", 1'b1, o[0])
    `CHK("id bus oe", 1'b1, bus_oe)
  endtask
  // spare codes are never shifted in; the pass path is checked with two patterns
  task automatic pass_codes();
    logic [127:0] pat [2] = '{128'h1, 128'h2};
    logic [127:0] o;
    ir(3'h7);
    foreach (pat[i]) begin
      dr(2, pat[i], o);
      `CHK("pass path", {pat[i][0], 1'b0}, o[1:0])
      `CHK("pass bus oe", 1'b1, bus_oe)
    end
  endtask
  task automatic chain(input logic [2:0] c, input logic [127:0] s, output logic [127:0] o);
    ir(c);
    dr(110, s, o);
    `CHK("ring capture", PINS, o[107:0])
    `CHK("chain length", s[0], o[109])
  endtask
  task automatic pin_tests();
    logic [127:0] o;
    chain(3'h4, S1, o);
    `CHK("gate preset", 1'b1, o[108])
    `CHK("sample drive en", 1'b0, drive_en)
    ir(3'h0);
    `CHK("drive en", 1'b1, drive_en)
    `CHK("preload", S1[108:1], drive_val)
    `CHK("gate low", S1[109], bus_oe)
    chain(3'h0, S2, o);
    `CHK("gate capture", S1[109], o[108])
    `CHK("gate high", S2[109], bus_oe)
    ir(3'h2);
    `CHK("float bus oe", 1'b0, bus_oe)
    chain(3'h2, S1, o);
    `CHK("float drive en", 1'b0, drive_en)
  endtask
  // the gate cell holds a low value here, so only the preset makes it high
  task automatic logic_reset();
    logic [31:0] q;
    scan(5, 32'h1F, 32'h0, q);
    scan(1, 32'h0, 32'h0, q);
    ir(3'h0);
    `CHK("preset gate", 1'b1, bus_oe)
    scan(5, 32'h1F, 32'h0, q);
    ident();
  endtask
  task automatic dll();
    logic [31:0] r;
    int n, i;
    wait_on(1'b1, 1'b1, n);
    `CHK("locked", 1'b1, locked)
    av(1'b0, `REG_DLL, 32'h0, r);
    `CHK("dll reg", 3'h5, r[2:0])
    av(1'b1, `REG_DLL, 32'h0, r);
    `CHK("pin off", 1'b0, link.dll_enable_pin)
    wait_on(1'b0, 1'b0, n);
    av(1'b1, `REG_DLL, 32'h1, r);
    wait_on(1'b0, 1'b1, n);
    `CHK("lock time", 1'b1, n >= LOCK && n <= LOCK + 6)
    for (i = 0; i < 2; i++) begin
      if (i == 0) begin
        unstable <= 1'b1;
        @(posedge sys_clk);
        unstable <= 1'b0;
        @(posedge sys_clk);
      end else av(1'b1, `REG_DLL, 32'h3, r);
      `CHK("ready drop", 1'b0, ready)
      wait_on(1'b1, 1'b1, n);
      `CHK("relock time", 1'b1, n >= LOCK - 4 && n <= LOCK + 4)
    end
  endtask
  task automatic results();
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ************************************************************
  // clock, sequence and watchdog
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    {rd, wr, unstable, rst_n} = '0;
    addr = '0;
    wdata = '0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    regs();
    ident();
    pass_codes();
    pin_tests();
    logic_reset();
    dll();
    results();
  end
  // far longer than the whole sequence needs at this test clock rate
  initial begin
    #8000000;
    fails++;
    results();
  end
endmodule
`default_nettype wire
